// ==== include/pwm_pkg.sv ====
package pwm_pkg;
    // ========================================
    // register byte offsets
    localparam logic [7:0] HALF_PERIOD_OFS = 8'h00;
    localparam logic [7:0] DEAD_TIME_OFS = 8'h04;
    localparam logic [7:0] PULSE_DEL_OFS = 8'h08;
    localparam logic [7:0] SYNC_WIDTH_OFS = 8'h0C;
    localparam logic [7:0] DUTY_A_OFS = 8'h10;
    localparam logic [7:0] DUTY_B_OFS = 8'h14;
    localparam logic [7:0] DUTY_C_OFS = 8'h18;
    localparam logic [7:0] SEGMENT_OFS = 8'h1C;
    localparam logic [7:0] GATE_CHOP_OFS = 8'h20;
    localparam logic [7:0] SW_TRIP_OFS = 8'h24;
    localparam logic [7:0] MODE_CTRL_OFS = 8'h28;
    localparam logic [7:0] SYS_STATUS_OFS = 8'h2C;
    // ========================================
    // field positions
    localparam int MODE_DOUBLE_BIT = 6;
    localparam int STAT_TRIP_BIT = 0;
    localparam int STAT_SHUTDOWN_BIT = 1;
    localparam int STAT_HALF_BIT = 3;
    localparam int SEG_DIS_LSB = 3;
    localparam int GATE_HI_EN_BIT = 8;
    localparam int GATE_LO_EN_BIT = 9;
    // ========================================
    // widths and reset values
    localparam int DT_W = 10;
    localparam int PD_W = 10;
    localparam int SW_W = 8;
    localparam int SEG_W = 9;
    localparam int GATE_W = 10;
    localparam logic [15:0] HALF_PERIOD_RST = 16'h03E8;
    localparam logic [SW_W-1:0] SYNC_WIDTH_RST = 8'h27;
endpackage : pwm_pkg

// ==== rtl/phase_gen.sv ====
`timescale 1ns/1ns
module phase_gen #(
    parameter int CW = 16
) (
    input wire logic [CW-1:0] cnt, // triangle position
    input wire logic [CW-1:0] half_period, // active half period
    input wire logic [CW-1:0] duty, // active duty count
    input wire logic [pwm_pkg::DT_W-1:0] dead_time, // active dead time
    input wire logic [pwm_pkg::PD_W-1:0] min_pulse, // deletion width
    output logic hi, // high-side waveform
    output logic lo // low-side waveform
);
    logic [CW+1:0] th;
    logic [CW+1:0] hi_edge;
    logic [CW+1:0] lo_edge;

    // on-time centred on the half-period turn point
    always_comb begin
        th = (duty >= half_period) ? '0 :
            {2'b00, half_period} - {2'b00, duty};
        hi_edge = th + {{(CW+2-pwm_pkg::DT_W){1'b0}}, dead_time};
        lo_edge = (th > {{(CW+2-pwm_pkg::DT_W){1'b0}}, dead_time}) ?
            th - {{(CW+2-pwm_pkg::DT_W){1'b0}}, dead_time} : '0;
        // pulses narrower than the deletion width are dropped
        hi = ({2'b00, cnt} >= hi_edge) && ({2'b00, half_period} >=
            hi_edge + {{(CW+2-pwm_pkg::PD_W){1'b0}}, min_pulse});
        lo = ({2'b00, cnt} < lo_edge) &&
            (lo_edge >= {{(CW+2-pwm_pkg::PD_W){1'b0}}, min_pulse});
    end
endmodule : phase_gen

// ==== rtl/three_phase_pwm.sv ====
// Our own choices: the address map and the APB slave port.
`timescale 1ns/1ns
module three_phase_pwm #(
    parameter int CW = 16
) (
    input wire logic clk_sys, // instruction-rate clock
    input wire logic rstn, // synchronous reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    input wire logic trip_in_n, // external trip, active low
    input wire logic current_sense_in, // comparator: high above trip level
    output logic phase_a_high_out, // high-side a
    output logic phase_a_low_out, // low-side a
    output logic phase_b_high_out, // high-side b
    output logic phase_b_low_out, // low-side b
    output logic phase_c_high_out, // high-side c
    output logic phase_c_low_out, // low-side c
    output logic period_sync_pulse, // sync pulse to adc
    output logic sync_irq, // one-cycle sync interrupt
    output logic trip_irq // one-cycle shutdown interrupt
);
    // ========================================
    // state
    typedef struct packed {
        logic [CW-1:0] hp_sh;
        logic [pwm_pkg::DT_W-1:0] dt_sh;
        logic [pwm_pkg::PD_W-1:0] pd_sh;
        logic [pwm_pkg::SW_W-1:0] sw_sh;
        logic [2:0][CW-1:0] duty_sh;
        logic [pwm_pkg::SEG_W-1:0] seg_sh;
        logic [pwm_pkg::GATE_W-1:0] gate_r;
        logic mode_dbl;
        logic swt;
        logic sd_latched;
        logic sd_prev;
        logic restart;
        logic [CW-1:0] hp_a;
        logic [pwm_pkg::DT_W-1:0] dt_a;
        logic [pwm_pkg::PD_W-1:0] pd_a;
        logic [2:0][CW-1:0] duty_a;
        logic [pwm_pkg::SEG_W-1:0] seg_a;
        logic [CW-1:0] cnt;
        logic half;
        logic [pwm_pkg::SW_W-1:0] sync_cnt;
        logic sync_o;
        logic sync_irq;
        logic trip_irq;
        logic [7:0] chop_cnt;
        logic chop;
        logic [5:0] pwm;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } state_t;

    state_t st_r;
    state_t st_nxt;
    logic [2:0] raw_hi;
    logic [2:0] raw_lo;
    logic [5:0] out_r;
    logic kill_n;
    logic sd_src;
    logic sd_any;
    logic wr_acc;
    logic setup;
    logic last;
    logic load;

    // ========================================
    // timing unit, one per phase
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_phase
            phase_gen #(.CW(CW)) u_phase (
                .cnt(st_r.cnt),
                .half_period(st_r.hp_a),
                .duty(st_r.duty_a[g]),
                .dead_time(st_r.dt_a),
                .min_pulse(st_r.pd_a),
                .hi(raw_hi[g]),
                .lo(raw_lo[g])
            );
        end
    endgenerate

    // ========================================
    // next state
    always_comb begin
        st_nxt = st_r;
        setup = psel && !penable;
        wr_acc = psel && penable && st_r.pready && pwrite;
        sd_src = !trip_in_n || current_sense_in || st_r.swt;
        sd_any = sd_src || st_r.sd_latched;
        last = ({1'b0, st_r.cnt} + 17'h00001) >= {1'b0, st_r.hp_a};
        load = 1'b0;

        // apb: answer in the first access cycle
        st_nxt.pready = setup;
        st_nxt.pslverr = 1'b0;
        if (setup) begin
            st_nxt.prdata = 32'h00000000;
            case (paddr)
                pwm_pkg::HALF_PERIOD_OFS: st_nxt.prdata[CW-1:0] = st_r.hp_sh;
                pwm_pkg::DEAD_TIME_OFS:
                    st_nxt.prdata[pwm_pkg::DT_W-1:0] = st_r.dt_sh;
                pwm_pkg::PULSE_DEL_OFS:
                    st_nxt.prdata[pwm_pkg::PD_W-1:0] = st_r.pd_sh;
                pwm_pkg::SYNC_WIDTH_OFS:
                    st_nxt.prdata[pwm_pkg::SW_W-1:0] = st_r.sw_sh;
                pwm_pkg::DUTY_A_OFS: st_nxt.prdata[CW-1:0] = st_r.duty_sh[0];
                pwm_pkg::DUTY_B_OFS: st_nxt.prdata[CW-1:0] = st_r.duty_sh[1];
                pwm_pkg::DUTY_C_OFS: st_nxt.prdata[CW-1:0] = st_r.duty_sh[2];
                pwm_pkg::SEGMENT_OFS:
                    st_nxt.prdata[pwm_pkg::SEG_W-1:0] = st_r.seg_sh;
                pwm_pkg::GATE_CHOP_OFS:
                    st_nxt.prdata[pwm_pkg::GATE_W-1:0] = st_r.gate_r;
                pwm_pkg::SW_TRIP_OFS: st_nxt.prdata[0] = st_r.swt;
                pwm_pkg::MODE_CTRL_OFS:
                    st_nxt.prdata[pwm_pkg::MODE_DOUBLE_BIT] = st_r.mode_dbl;
                pwm_pkg::SYS_STATUS_OFS: begin
                    st_nxt.prdata[pwm_pkg::STAT_TRIP_BIT] = trip_in_n;
                    st_nxt.prdata[pwm_pkg::STAT_SHUTDOWN_BIT] = sd_any;
                    st_nxt.prdata[pwm_pkg::STAT_HALF_BIT] = st_r.half;
                end
                default: st_nxt.pslverr = 1'b1;
            endcase
        end

        if (wr_acc) begin
            case (paddr)
                pwm_pkg::HALF_PERIOD_OFS: st_nxt.hp_sh = pwdata[CW-1:0];
                pwm_pkg::DEAD_TIME_OFS:
                    st_nxt.dt_sh = pwdata[pwm_pkg::DT_W-1:0];
                pwm_pkg::PULSE_DEL_OFS:
                    st_nxt.pd_sh = pwdata[pwm_pkg::PD_W-1:0];
                pwm_pkg::SYNC_WIDTH_OFS:
                    st_nxt.sw_sh = pwdata[pwm_pkg::SW_W-1:0];
                pwm_pkg::DUTY_A_OFS: st_nxt.duty_sh[0] = pwdata[CW-1:0];
                pwm_pkg::DUTY_B_OFS: st_nxt.duty_sh[1] = pwdata[CW-1:0];
                pwm_pkg::DUTY_C_OFS: st_nxt.duty_sh[2] = pwdata[CW-1:0];
                pwm_pkg::SEGMENT_OFS:
                    st_nxt.seg_sh = pwdata[pwm_pkg::SEG_W-1:0];
                pwm_pkg::GATE_CHOP_OFS:
                    st_nxt.gate_r = pwdata[pwm_pkg::GATE_W-1:0];
                pwm_pkg::SW_TRIP_OFS: st_nxt.swt = 1'b1;
                pwm_pkg::MODE_CTRL_OFS:
                    st_nxt.mode_dbl = pwdata[pwm_pkg::MODE_DOUBLE_BIT];
                pwm_pkg::SYS_STATUS_OFS:
                    if (pwdata[pwm_pkg::STAT_SHUTDOWN_BIT]) begin
                        st_nxt.swt = 1'b0;
                        st_nxt.sd_latched = 1'b0;
                    end
                default: ;
            endcase
        end

        // ========================================
        // shutdown controller; a live source beats the clear
        // only a live pin or a trip still pending after this cycle's
        // write re-arms the latch; the old soft trip must not, or a
        // status clear could never end a software shutdown
        if (!trip_in_n || current_sense_in || st_nxt.swt) begin
            st_nxt.sd_latched = 1'b1;
        end
        st_nxt.sd_prev = sd_src;
        st_nxt.trip_irq = sd_src && !st_r.sd_prev;

        // ========================================
        // timing unit: up half then down half
        st_nxt.sync_irq = 1'b0;
        if (sd_any) begin
            st_nxt.cnt = '0;
            st_nxt.half = 1'b0;
            st_nxt.restart = 1'b1;
            st_nxt.sync_o = 1'b0;
            st_nxt.sync_cnt = '0;
        end else begin
            if (st_r.restart) begin
                st_nxt.restart = 1'b0;
                load = 1'b1;
            end else if (!st_r.half) begin
                if (last) begin
                    st_nxt.half = 1'b1;
                    load = st_r.mode_dbl;
                end else begin
                    st_nxt.cnt = st_r.cnt + 1'b1;
                end
            end else if (st_r.cnt == '0) begin
                st_nxt.half = 1'b0;
                load = 1'b1;
            end else begin
                st_nxt.cnt = st_r.cnt - 1'b1;
            end
            if (st_r.sync_cnt != '0) begin
                st_nxt.sync_cnt = st_r.sync_cnt - 1'b1;
            end else begin
                st_nxt.sync_o = 1'b0;
            end
            // rising sync edge latches every shadow register
            if (load) begin
                st_nxt.hp_a = st_r.hp_sh;
                st_nxt.dt_a = st_r.dt_sh;
                st_nxt.pd_a = st_r.pd_sh;
                st_nxt.duty_a = st_r.duty_sh;
                st_nxt.seg_a = st_r.seg_sh;
                st_nxt.sync_cnt = st_r.sw_sh;
                st_nxt.sync_o = 1'b1;
                st_nxt.sync_irq = 1'b1;
            end
        end

        // ========================================
        // gate chopping divider
        if (st_r.chop_cnt >= st_r.gate_r[7:0]) begin
            st_nxt.chop_cnt = 8'h00;
            st_nxt.chop = !st_r.chop;
        end else begin
            st_nxt.chop_cnt = st_r.chop_cnt + 8'h01;
        end

        // ========================================
        // output control: crossover, enables, chop
        for (int p = 0; p < 3; p++) begin
            st_nxt.pwm[2*p] = st_r.seg_a[p] ? raw_lo[p] : raw_hi[p];
            st_nxt.pwm[2*p+1] = st_r.seg_a[p] ? raw_hi[p] : raw_lo[p];
            if (st_r.gate_r[pwm_pkg::GATE_HI_EN_BIT]) begin
                st_nxt.pwm[2*p] = st_nxt.pwm[2*p] && st_r.chop;
            end
            if (st_r.gate_r[pwm_pkg::GATE_LO_EN_BIT]) begin
                st_nxt.pwm[2*p+1] = st_nxt.pwm[2*p+1] && !st_r.chop;
            end
        end
        st_nxt.pwm = st_nxt.pwm &
            ~st_r.seg_a[pwm_pkg::SEG_DIS_LSB +: 6];
        if (sd_any) begin
            st_nxt.pwm = 6'b000000;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            st_r <= '0;
            st_r.hp_sh <= pwm_pkg::HALF_PERIOD_RST;
            st_r.hp_a <= pwm_pkg::HALF_PERIOD_RST;
            st_r.sw_sh <= pwm_pkg::SYNC_WIDTH_RST;
            st_r.restart <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ========================================
    // pin stage: cleared with no clock by hardware trips
    // the kill term is combinational so a stopped clock still trips
    assign kill_n = trip_in_n && !current_sense_in;

    always_ff @(posedge clk_sys or negedge kill_n) begin
        if (!kill_n) begin
            out_r <= 6'b000000;
        end else if (!rstn) begin
            out_r <= 6'b000000;
        end else begin
            out_r <= st_r.pwm;
        end
    end

    assign phase_a_high_out = out_r[0];
    assign phase_a_low_out = out_r[1];
    assign phase_b_high_out = out_r[2];
    assign phase_b_low_out = out_r[3];
    assign phase_c_high_out = out_r[4];
    assign phase_c_low_out = out_r[5];
    assign period_sync_pulse = st_r.sync_o;
    assign sync_irq = st_r.sync_irq;
    assign trip_irq = st_r.trip_irq;
    assign pready = st_r.pready;
    assign pslverr = st_r.pslverr;
    assign prdata = st_r.prdata;

    // ========================================
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    logic [8:0] sync_len;
    logic [pwm_pkg::SW_W-1:0] sync_want;
    always_ff @(posedge clk_sys) begin
        if (!rstn || !st_r.sync_o) begin
            sync_len <= 9'h000;
            sync_want <= st_nxt.sync_cnt;
        end else begin
            sync_len <= sync_len + 9'h001;
        end
    end

    sequence sd_write_s;
        wr_acc && paddr == pwm_pkg::SW_TRIP_OFS;
    endsequence
    sequence outputs_off_s;
        out_r == 6'b000000;
    endsequence

    // pin flops are cleared with no clock, so this holds at every edge
    trip_forces_off_a: assert property (!trip_in_n |-> out_r == 6'b0)
        else $error("outputs on while trip low");
    // the count already holds the whole pulse on the cycle it drops
    sync_width_a: assert property (
        $fell(st_r.sync_o) && !$past(sd_any)
        |-> sync_len == {1'b0, sync_want} + 9'h001)
        else $error("sync pulse width wrong");
    sync_reset_a: assert property ($rose(rstn) |->
        st_r.sw_sh == pwm_pkg::SYNC_WIDTH_RST)
        else $error("sync width reset value wrong");
    double_mid_a: assert property (
        $rose(st_r.half) && $past(st_r.mode_dbl)
        |-> st_r.sync_irq && st_r.sync_o)
        else $error("no midpoint sync in double mode");
    single_mid_a: assert property (
        $rose(st_r.half) && !$past(st_r.mode_dbl) |-> !st_r.sync_irq)
        else $error("midpoint sync in single mode");
    soft_trip_a: assert property (
        sd_write_s |=> ##1 st_r.sd_latched ##2 outputs_off_s)
        else $error("software trip did not shut down");
    trip_irq_a: assert property (
        $rose(sd_src) |=> trip_irq ##1 !trip_irq)
        else $error("shutdown interrupt not single");
    status_read_a: assert property (
        setup && !pwrite && paddr == pwm_pkg::SYS_STATUS_OFS
        |=> prdata[pwm_pkg::STAT_TRIP_BIT] == $past(trip_in_n))
        else $error("status trip bit wrong");
    timer_stop_a: assert property (
        sd_any |=> st_r.cnt == '0 && !st_r.sync_o)
        else $error("timer ran during shutdown");
    // a disabled high side stays off on the next cycle
    seg_disable_a: assert property (
        st_r.seg_a[pwm_pkg::SEG_DIS_LSB + 2] |=> !st_r.pwm[2])
        else $error("disabled output driven");
    // dead time, crossover and chop must never short a leg
    no_shoot_a: assert property (!((out_r[0] && out_r[1]) ||
        (out_r[2] && out_r[3]) || (out_r[4] && out_r[5])))
        else $error("both switches of a leg on");
endmodule : three_phase_pwm

// ==== sim/gate_stage.sv ====
`timescale 1ns/1ns
module gate_stage (
    input wire logic clk_sys, // reference clock for the monitors
    input wire logic [5:0] gate, // ah al bh bl ch cl
    input wire logic trip_req, // bench asks for a trip
    input wire logic oc_req, // bench asks for overcurrent
    output logic trip_in_n, // trip line, pulled up when idle
    output logic current_sense_in, // comparator, high above level
    output logic [31:0] shoot_cnt, // cycles with a shorted leg
    output logic [31:0] dead_gap // last both-off run of leg c
);
    logic [31:0] off_run;

    // ========================================
    // fault sources
    // line idles high through its pull-up
    assign trip_in_n = ~trip_req;
    assign current_sense_in = oc_req;

    // ========================================
    // leg monitors
    initial begin
        shoot_cnt = 32'h0;
        dead_gap = 32'h0;
        off_run = 32'h0;
    end
    always @(posedge clk_sys) begin
        if ((gate[5] & gate[4]) | (gate[3] & gate[2]) | (gate[1] & gate[0]))
            shoot_cnt <= shoot_cnt + 32'h1;
        if (gate[1] === 1'b0 && gate[0] === 1'b0) begin
            off_run <= off_run + 32'h1;
        end else begin
            if (off_run != 32'h0)
                dead_gap <= off_run;
            off_run <= 32'h0;
        end
    end
endmodule : gate_stage

// ==== sim/tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
    localparam logic [15:0] HP = 16'h0010;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic trip_req = 1'b0;
    logic oc_req = 1'b0;
    logic [31:0] prdata, shoot_cnt, dead_gap, rv;
    logic pready, pslverr, trip_in_n, current_sense_in;
    logic sync_p, sync_irq, trip_irq;
    logic [5:0] outs;
    logic [32:0] exp_q[$];
    int num_errors = 0;
    int n_checks = 0;
    int cycles = 0;
    int irq_cnt = 0;
    int seed = 85012;
    int gap, w, base;
    int on_cnt[6];

    always #2 clk_sys = ~clk_sys;

    three_phase_pwm #(.CW(16)) u_dut (
        .clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .trip_in_n(trip_in_n),
        .current_sense_in(current_sense_in),
        .phase_a_high_out(outs[5]), .phase_a_low_out(outs[4]),
        .phase_b_high_out(outs[3]), .phase_b_low_out(outs[2]),
        .phase_c_high_out(outs[1]), .phase_c_low_out(outs[0]),
        .period_sync_pulse(sync_p), .sync_irq(sync_irq), .trip_irq(trip_irq)
    );
    gate_stage u_gate (
        .clk_sys(clk_sys), .gate(outs), .trip_req(trip_req), .oc_req(oc_req),
        .trip_in_n(trip_in_n), .current_sense_in(current_sense_in),
        .shoot_cnt(shoot_cnt), .dead_gap(dead_gap)
    );

    // ========================================
    // checking and reporting
    task automatic fail(input string msg);
        num_errors++;
        $display("CHECK FAILED at %0t: %s", $time, msg);
    endtask : fail
    task automatic check(input logic [32:0] got, input logic [32:0] e,
                         input string msg);
        n_checks++;
        if (got !== e)
            fail($sformatf("%s got %h want %h", msg, got, e));
    endtask : check
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : tally_and_finish

    // read results are matched against the oldest note
    always @(posedge clk_sys) begin
        cycles++;
        if (trip_irq === 1'b1)
            irq_cnt++;
        if (psel && penable && pready === 1'b1 && !pwrite)
            check({pslverr, prdata}, exp_q.pop_front(), "read");
        if (cycles == 20000) begin
            fail("timeout");
            tally_and_finish();
        end
    end

    // ========================================
    // bus and timing helpers
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        // idle edge so the next setup never lands in this time step
        @(posedge clk_sys);
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask : rd
    task automatic wait_sync(input int k);
        gap = 0;
        while (k > 0 && gap < 3000) begin
            @(posedge clk_sys);
            gap++;
            if (sync_irq === 1'b1)
                k--;
        end
        if (k > 0)
            fail("no sync");
    endtask : wait_sync
    task automatic meas_width;
        w = 0;
        do begin
            w++;
            @(posedge clk_sys);
        end while (sync_p === 1'b1 && w < 300);
    endtask : meas_width
    task automatic expect_const(input logic [5:0] e, input logic [5:0] m);
        on_cnt = '{default: 0};
        repeat (32) begin
            @(posedge clk_sys);
            for (int i = 0; i < 6; i++)
                on_cnt[i] += int'(outs[i] === 1'b1);
        end
        for (int i = 0; i < 6; i++)
            if (m[i])
                check(33'(on_cnt[i]), e[i] ? 33'h20 : 33'h0, "level");
    endtask : expect_const

    // ========================================
    // scenarios
    initial begin
        repeat (5) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        rd(pwm_pkg::HALF_PERIOD_OFS, 33'h3E8);
        rd(pwm_pkg::SYNC_WIDTH_OFS, 33'h27);
        rd(pwm_pkg::MODE_CTRL_OFS, 33'h0);
        rd(8'h30, 33'h100000000);
        rv = $random(seed);
        apb(1'b1, pwm_pkg::DEAD_TIME_OFS, rv);
        rd(pwm_pkg::DEAD_TIME_OFS, {23'h0, rv[9:0]});
        wait_sync(1);
        meas_width();
        check(33'(w), 33'h28, "default sync width");
        $display("test reset_values done");

        apb(1'b1, pwm_pkg::HALF_PERIOD_OFS, {16'h0, HP});
        apb(1'b1, pwm_pkg::SYNC_WIDTH_OFS, 32'h3);
        apb(1'b1, pwm_pkg::DEAD_TIME_OFS, 32'h0);
        apb(1'b1, pwm_pkg::DUTY_A_OFS, 32'h0);
        apb(1'b1, pwm_pkg::DUTY_B_OFS, {16'h0, HP});
        rv = 32'h4 + ($random(seed) & 32'h7);
        apb(1'b1, pwm_pkg::DUTY_C_OFS, rv);
        wait_sync(2);
        meas_width();
        check(33'(w), 33'h4, "sync width");
        wait_sync(1);
        wait_sync(1);
        check(33'(gap), 33'h20, "single period");
        expect_const(6'b011000, 6'b111100);
        apb(1'b1, pwm_pkg::SEGMENT_OFS, 32'h21);
        wait_sync(2);
        expect_const(6'b100000, 6'b111100);
        apb(1'b1, pwm_pkg::SEGMENT_OFS, 32'h0);
        $display("test pattern done");

        // divider 1 gives a four-cycle chop, half of any 32 cycles on
        apb(1'b1, pwm_pkg::GATE_CHOP_OFS, 32'h301);
        wait_sync(2);
        expect_const(6'b000000, 6'b000000);
        check(33'(on_cnt[4]), 33'h10, "low chop");
        check(33'(on_cnt[3]), 33'h10, "high chop");
        apb(1'b1, pwm_pkg::GATE_CHOP_OFS, 32'h0);
        rv = 32'h1 + ($random(seed) & 32'h1);
        apb(1'b1, pwm_pkg::DEAD_TIME_OFS, rv);
        wait_sync(3);
        check({1'b0, dead_gap}, {rv, 1'b0}, "dead time");
        // a deletion width above every pulse drops them all
        apb(1'b1, pwm_pkg::PULSE_DEL_OFS, 32'h3FF);
        wait_sync(2);
        expect_const(6'b000000, 6'b111111);
        apb(1'b1, pwm_pkg::PULSE_DEL_OFS, 32'h0);
        $display("test chop_dead done");

        apb(1'b1, pwm_pkg::MODE_CTRL_OFS, 32'h40);
        rd(pwm_pkg::MODE_CTRL_OFS, 33'h40);
        base = irq_cnt;
        apb(1'b1, pwm_pkg::SW_TRIP_OFS, 32'h1);
        rd(pwm_pkg::SW_TRIP_OFS, 33'h1);
        rd(pwm_pkg::SYS_STATUS_OFS, 33'h3);
        expect_const(6'b000000, 6'b111111);
        check(33'(irq_cnt - base), 33'h1, "sw trip irq");
        apb(1'b1, pwm_pkg::SYS_STATUS_OFS, 32'h2);
        wait_sync(1);
        rd(pwm_pkg::SYS_STATUS_OFS, 33'h1);
        wait_sync(1);
        rd(pwm_pkg::SYS_STATUS_OFS, 33'h9);
        wait_sync(1);
        wait_sync(1);
        check(33'(gap), 33'(HP), "double period");
        $display("test double_update done");

        for (int s = 0; s < 2; s++) begin
            check(33'(|outs), 33'h1, "live");
            base = irq_cnt;
            if (s == 0)
                trip_req <= 1'b1;
            else
                oc_req <= 1'b1;
            @(negedge clk_sys);
            check({27'h0, outs}, 33'h0, "async off");
            @(posedge clk_sys);
            expect_const(6'b000000, 6'b111111);
            check(33'(irq_cnt - base), 33'h1, "hw trip irq");
            rd(pwm_pkg::SYS_STATUS_OFS, s ? 33'h3 : 33'h2);
            trip_req <= 1'b0;
            oc_req <= 1'b0;
            repeat (4) @(posedge clk_sys);
            apb(1'b1, pwm_pkg::SYS_STATUS_OFS, 32'h2);
            wait_sync(2);
        end
        check({1'b0, shoot_cnt}, 33'h0, "shoot through");
        $display("test shutdown done");
        tally_and_finish();
    end
endmodule : tb_top
